// File: common/ssipt_pkg.sv
package ssipt_pkg;
  // =====================================================================
  // word format
  // =====================================================================
  localparam int unsigned POSITION_BITS     = 14;
  localparam int unsigned WORD_BITS         = 25;                // frame length in clock bits
  localparam int unsigned SPECIAL_BIT_POS   = 10;                // special bit sits below position field
  localparam int unsigned RING_MAX_BITS     = 13;                // repetition allowed up to this length
  localparam int unsigned BIT_COUNT_BITS    = 5;

  // =====================================================================
  // timing
  // =====================================================================
  localparam int unsigned CLOCK_HZ          = 40_000_000;
  localparam int unsigned HOLD_LOW_NS       = 20_000;            // nominal hold low interval, 20 us
  localparam int unsigned HOLD_LOW_CYCLES   = (HOLD_LOW_NS / 1000) * (CLOCK_HZ / 1_000_000);
  localparam int unsigned TIMER_BITS        = 11;
  localparam logic [13:0] POSITION_RESET    = 14'h0000;

  // link-facing sequencer state
  typedef enum logic [1:0] {SSIPT_IDLE, SSIPT_SHIFT, SSIPT_HOLD} ssipt_state_e;
endpackage

// File: common/ssipt_link_if.sv
`timescale 1ns/10ps
// sampled link events travelling from the edge detector to the transmitter
interface ssipt_link_if;
  logic clock_level;
  logic clock_fall;
  logic clock_rise;

  modport detector (output clock_level, output clock_fall, output clock_rise);
  modport sequencer (input clock_level, input clock_fall, input clock_rise);
endinterface

// File: design/ssipt_edge_detect.sv
`timescale 1ns/10ps
module ssipt_edge_detect
(
  input  wire logic  i_clock,
  input  wire logic  i_reset,
  input  wire logic  i_link_clock,
  ssipt_link_if.detector link
);
  // =====================================================================
  // two-stage synchroniser, then edge detection on the settled copy
  // =====================================================================
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  // idle clock rests high, so flops reset high to avoid a phantom rise
  always_comb
  begin
    meta_next = i_link_clock;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign link.clock_level = sync_reg;
  assign link.clock_fall  = last_reg & ~sync_reg;
  assign link.clock_rise  = ~last_reg & sync_reg;
endmodule // ssipt_edge_detect

// File: design/ssipt_transmitter.sv
`timescale 1ns/10ps
// What this block does
// - idle, data line and clock line rest high.
// - first clock fall captures position bits and special bit into shift register.
// - first rising edge puts the word's MSB on data output.
// - each later rising edge advances to next lower bit.
// - after LSB, data held low until hold low interval ends, then high.
// - hold low timer starts on last falling edge of burst.
// - clocking without pause after last fall resends the captured word in ring mode, otherwise captures a fresh word.
// - each word occupies its length in clock bits (at most 13 in ring mode) plus one low bit before repetition.
// - pulse length+2 decides repetition (15th for 13 bits); late pulse gives a fresh word.
// - ring repetition only for word lengths up to 13 bits.
// - swapped clock pair shifts data by one; controller must wire correctly.
// - position field is 14 bits, 16384 steps per revolution.
// - position is Gray coded, counting down clockwise.
// - link clock rate lies between 0.1 and 2 Mbit/s.
module ssipt_transmitter
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_link_clock,
  input  wire logic [13:0] i_position_bits,
  input  wire logic        i_special_bit,
  input  wire logic [4:0]  i_word_bits,
  input  wire logic        i_ring_enable,
  output logic             o_data,
  output logic             o_busy
);
  // =====================================================================
  // link clock sampling
  // =====================================================================
  ssipt_link_if link ();

  // a swapped clock pair turns each fall into a rise, sliding the word by one bit
  // sync plus edge flop cost at most 75 ns, well inside one bit at the top link rate
  ssipt_edge_detect u_edge
  (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_link_clock (i_link_clock),
    .link         (link.detector)
  );

  // =====================================================================
  // gray encoding of the position count
  // =====================================================================
  logic [13:0] gray_position;

  // source counts down clockwise; gray keeps one bit change per step
  assign gray_position = i_position_bits ^ (i_position_bits >> 1);

  // =====================================================================
  // sequencer
  // =====================================================================
  ssipt_pkg::ssipt_state_e state_reg;
  ssipt_pkg::ssipt_state_e state_next;
  logic [24:0] shift_reg;
  logic [24:0] shift_next;
  logic [24:0] saved_reg;
  logic [24:0] saved_next;
  logic [4:0]  count_reg;
  logic [4:0]  count_next;
  logic [10:0] timer_reg;
  logic [10:0] timer_next;
  logic        data_reg;
  logic        data_next;
  logic [4:0]  length;
  logic [24:0] captured;
  logic        ring_ok;

  // word length limited to 25; zero or larger falls back to full frame
  assign length  = (i_word_bits == 5'h00 || i_word_bits > 5'(ssipt_pkg::WORD_BITS)) ?
                   5'(ssipt_pkg::WORD_BITS) : i_word_bits;
  assign ring_ok = i_ring_enable && (length <= 5'(ssipt_pkg::RING_MAX_BITS));

  // captured word left aligned: position, special bit, zero padding
  assign captured = {gray_position, i_special_bit, 10'h000};

  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    saved_next = saved_reg;
    count_next = count_reg;
    timer_next = timer_reg;
    data_next  = data_reg;
    case (state_reg)
      ssipt_pkg::SSIPT_IDLE:
      begin
        data_next = 1'b1;
        if (link.clock_fall)
        begin
          shift_next = captured;
          saved_next = captured;
          count_next = 5'h00;
          state_next = ssipt_pkg::SSIPT_SHIFT;
        end
      end
      ssipt_pkg::SSIPT_SHIFT:
      begin
        if (link.clock_rise)
        begin
          if (count_reg < length)
          begin
            data_next  = shift_reg[24];
            shift_next = {shift_reg[23:0], 1'b0};
          end
          else
          begin
            data_next = 1'b0;
          end
          count_next = 5'(count_reg + 5'h01);
        end
        else if (link.clock_fall && count_reg >= length)
        begin
          // last fall of the burst starts the timer; the lsb stays up until the
          // trailing rise, since the controller still samples it in this low phase
          timer_next = 11'(ssipt_pkg::HOLD_LOW_CYCLES);
          state_next = ssipt_pkg::SSIPT_HOLD;
        end
      end
      default:
      begin
        // trailing rise drops the line; a fall before timeout is the repetition decision
        if (link.clock_rise)
        begin
          data_next = 1'b0;
        end
        if (link.clock_fall)
        begin
          // ring mode replays the first word, otherwise fresh capture
          shift_next = ring_ok ? saved_reg : captured;
          saved_next = ring_ok ? saved_reg : captured;
          count_next = 5'h00;
          state_next = ssipt_pkg::SSIPT_SHIFT;
        end
        else if (timer_reg == 11'h000)
        begin
          data_next  = 1'b1;
          state_next = ssipt_pkg::SSIPT_IDLE;
        end
        else
        begin
          timer_next = 11'(timer_reg - 11'h001);
        end
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_reg <= ssipt_pkg::SSIPT_IDLE;
      shift_reg <= 25'h000_0000;
      saved_reg <= 25'h000_0000;
      count_reg <= 5'h00;
      timer_reg <= 11'h000;
      data_reg  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      saved_reg <= saved_next;
      count_reg <= count_next;
      timer_reg <= timer_next;
      data_reg  <= data_next;
    end
  end

  assign o_data = data_reg;
  assign o_busy = (state_reg != ssipt_pkg::SSIPT_IDLE);
endmodule // ssipt_transmitter

// File: verification/ssipt_transmitter_props.sv
`timescale 1ns/10ps
// ====================================================
// link timing checker
module ssipt_transmitter_props
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_link_clock,
  input wire logic [13:0] i_position_bits,
  input wire logic        i_special_bit,
  input wire logic [4:0]  i_word_bits,
  input wire logic        i_ring_enable,
  input wire logic        o_data,
  input wire logic        o_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic [9:0] rise_cnt_reg, rise_cnt_next;
  logic       link_reg;
  // cycles since the last link rise; saturates so long idles stay quiet
  always_comb
  begin
    rise_cnt_next = (rise_cnt_reg == 10'h3ff || rise_cnt_reg == 10'h000) ? rise_cnt_reg : rise_cnt_reg + 10'h001;
    if (i_link_clock && !link_reg) rise_cnt_next = 10'h001;
    if (i_reset) rise_cnt_next = 10'h000;
  end
  // register the counter and the previous link level
  always_ff @(posedge i_clock)
  begin
    rise_cnt_reg <= rise_cnt_next;
    link_reg     <= i_link_clock;
  end
  sequence idle_fall_s;
    !o_busy ##0 $fell(i_link_clock);
  endsequence
  sequence hold_low_s;
    !o_data [*8];
  endsequence
  idle_high_a: assert property (!o_busy |-> o_data) else $error("data not high at idle");
  reset_idle_a: assert property (disable iff (1'b0) i_reset |=> o_data && !o_busy) else $error("reset not idle");
  capture_busy_a: assert property (idle_fall_s |-> ##[2:6] o_busy) else $error("fall not taken");
  msb_first_a: assert property (idle_fall_s |-> ##10 o_data == $past(i_position_bits[13], 10)) else $error("bad msb");
  bit_timing_a: assert property ($changed(o_data) |-> rise_cnt_reg inside {[2:8]} || rise_cnt_reg > 10'h2bc)
    else $error("data moved off a rise");
  hold_low_a: assert property (o_busy && rise_cnt_reg == 10'h014 |-> hold_low_s) else $error("hold not low");
  hold_min_a: assert property (rise_cnt_reg == 10'h17c |-> o_busy && !o_data) else $error("hold too short");
  hold_end_a: assert property (rise_cnt_reg == 10'h3e8 |-> !o_busy) else $error("hold too long");
endmodule // ssipt_transmitter_props
bind ssipt_transmitter ssipt_transmitter_props chk (.i_clock(i_clock), .i_reset(i_reset), .i_link_clock(i_link_clock),
  .i_position_bits(i_position_bits), .i_special_bit(i_special_bit), .i_word_bits(i_word_bits),
  .i_ring_enable(i_ring_enable), .o_data(o_data), .o_busy(o_busy));

// File: verification/ssipt_master_model.sv
`timescale 1ns/10ps
// ====================================================
// controller side: clock bursts of 200 ns pulses, idle high
module ssipt_master_model
(
  input  wire logic i_data,
  output logic      o_link_clock
);
  initial o_link_clock = 1'b1;
  // bit k is read just before rise k+1, since data lags a rise by the sync delay; callers wait out the hold
  task automatic burst(input int n, output logic [63:0] got);
    got = 64'h0000_0000_0000_0000;
    for (int k = 0; k < n; k++)
    begin
      #100 o_link_clock = 1'b0;
      #100 if (k > 0) got = {got[62:0], i_data};
      o_link_clock = 1'b1;
    end
  endtask
endmodule // ssipt_master_model

// File: verification/ssipt_transmitter_tb.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
// ====================================================
// bench top
module ssipt_transmitter_tb;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        link_clock;
  logic [13:0] position_bits = 14'h0000;
  logic        special_bit = 1'b0;
  logic [4:0]  word_bits = 5'h19;
  logic        ring_enable = 1'b0;
  logic        data;
  logic        busy;
  logic [63:0] got;
  int          num_errors = 0;
  int          total_checks = 0;
  // 40 MHz clock
  initial forever #12.5 clock = ~clock;
  ssipt_transmitter dut (.i_clock(clock), .i_reset(reset), .i_link_clock(link_clock), .i_position_bits(position_bits),
    .i_special_bit(special_bit), .i_word_bits(word_bits), .i_ring_enable(ring_enable), .o_data(data), .o_busy(busy));
  ssipt_master_model master (.i_data(data), .o_link_clock(link_clock));
  // expected frame: gray position, special bit, zero fill
  function automatic logic [24:0] frame(input logic [13:0] p, input logic s);
    return {p ^ (p >> 1), s, 10'h000};
  endfunction
  // controller side conversion of the received gray position
  function automatic logic [13:0] gray_to_bin(input logic [13:0] g);
    logic [13:0] b;
    b[13] = g[13];
    for (int i = 12; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for the hold interval to run out; a stuck line ends the run
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1200)
    begin
      @(negedge clock);
      n++;
    end
    `CHECK({busy, data}, 2'b01)
    if (busy !== 1'b0) test_done();
  endtask
  // main sequence: single frames, then continuous clocking
  initial
  begin
    int          len;
    logic [24:0] exp;
    logic [24:0] exp2;
    void'($urandom(42811));
    repeat (8) @(negedge clock);
    reset = 1'b0;
    `CHECK({data, busy}, 2'b10)
    for (int t = 0; t < 8; t++)
    begin
      position_bits = (t == 0) ? 14'h0000 : (t == 1) ? 14'h3fff : 14'($urandom);
      special_bit = 1'($urandom);
      len = (t == 1) ? 1 : (t < 3) ? 25 : 1 + $urandom % 25;
      word_bits = (t == 2) ? 5'h00 : 5'(len); // zero reads as full length
      #3 master.burst(len + 1, got);
      `CHECK(got[24:0], frame(position_bits, special_bit) >> (25 - len))
      if (len >= 14) `CHECK(gray_to_bin(got[len - 1 -: 14]), position_bits)
      repeat (10) @(negedge clock);
      `CHECK(data, 1'b0)
      wait_idle();
      $display("frame test %0d done", t);
    end
    // position flips mid burst: only a ring word of 13 bits or less keeps the old capture
    for (int t = 0; t < 3; t++)
    begin
      len = 13 + t / 2;
      ring_enable = (t != 1);
      word_bits = 5'(len);
      position_bits = 14'($urandom);
      exp = frame(position_bits, special_bit) >> (25 - len);
      fork
        #3 master.burst(2 * len + 2, got);
        #1000 position_bits = ~position_bits;
      join
      exp2 = (t == 0) ? exp : frame(position_bits, special_bit) >> (25 - len);
      `CHECK(got, (64'(exp) << (len + 1)) | 64'(exp2))
      wait_idle();
      $display("ring test %0d done", t);
    end
    test_done();
  end
endmodule // ssipt_transmitter_tb
